// file: logic/gpio_pkg.sv
package gpio_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT0   = 8'h80;
   localparam logic [7:0] ADDR_PORT1   = 8'h90;
   localparam logic [7:0] ADDR_MOD_SEL = 8'h9f;
   localparam logic [7:0] ADDR_PORT2   = 8'ha0;
   localparam logic [7:0] ADDR_CFG     = 8'haf;
   localparam logic [7:0] ADDR_PU0     = 8'hb2;
   localparam logic [7:0] ADDR_PU1     = 8'hb3;
   localparam logic [7:0] ADDR_PU2     = 8'hb4;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CFG_CARRIER_EN_BIT = 4;
   localparam int SEL_P16            = 7;
   localparam int SEL_P15            = 6;
   localparam int SEL_P14            = 5;
   localparam int SEL_P11            = 4;
   localparam int SEL_P02            = 3;
   localparam int SEL_P07            = 2;
   localparam int SEL_P05            = 1;
   localparam int SEL_P03            = 0;
   localparam int PU2_RST_PIN_BIT    = 5;
   localparam int P2_PINS            = 3;
   localparam int P2_WO_BIT          = 3;

   // ------------------------------------------------------------
   // reset values and fixed read bits
   // ------------------------------------------------------------
   localparam logic [7:0] PORT_LATCH_RST = 8'hff;
   localparam logic [3:0] P2_LATCH_RST   = 4'hf;
   localparam logic [3:0] P2_UNUSED_RD   = 4'hf;
   localparam logic [7:0] MOD_SEL_RST    = 8'h00;
   localparam logic [7:0] PU_RST         = 8'h00;
   localparam logic [7:0] PU2_RD_MASK    = 8'h27;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ           = 250_000_000;
   localparam int CARRIER_HZ       = 38_000;
   localparam int CARRIER_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
endpackage

// file: logic/carrier_gen.sv
`timescale 1ns/1ns
`default_nettype none
module carrier_gen
   import gpio_pkg::*;
#(
   parameter int HALF_CYC = CARRIER_HALF_CYC
) (
   input  wire logic clk,     // core clock
   input  wire logic resetn,  // sync reset, active low
   output var  logic wave_ff  // free-running square wave
);
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

   logic [CW-1:0] cnt_ff;
   logic          tick_ff;

   // free-running so every modulated pin shares one phase
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end else if (cnt_ff == LAST) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + CW'(1);
         tick_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wave_ff <= 1'b0;
      end else if (tick_ff) begin
         wave_ff <= ~wave_ff;
      end
   end

   AST_CARRIER_TOGGLE: assert property (@(posedge clk) disable iff (!resetn)
      tick_ff |=> wave_ff != $past(wave_ff))
      else $error("carrier did not toggle on divider tick");
endmodule
`default_nettype wire

// file: logic/gpio_port.sv
// Summary of operation
// - latched one with pull-up: pin is input
// - pull-up pin drives latched zero low
// - pull-up disabled: open drain, never drives high
// - open-drain input needs latch one, released
// - modulated pin drives latch xor carrier
// - config bit 4 gates all modulation
// - select bits map to eight fixed pins
// - port 0 pull-up disable bits, reset zero
// - port 1 pull-up disable bits, reset zero
// - port 2 pull-up bits 2:0, reset-pin bit 5
// - port 0 latch read/write, resets to ones
// - port 1 latch read/write, resets to ones
// - read returns latch or pin per strobe
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module gpio_port
   import gpio_pkg::*;
(
   input  wire logic       clk,             // core clock, 250 MHz
   input  wire logic       resetn,          // sync reset, active low
   input  wire logic [7:0] addr,            // register address
   input  wire logic [7:0] wdata,           // write data
   input  wire logic       wr,              // write strobe
   input  wire logic       rd,              // read strobe
   input  wire logic       pin_read,        // with rd: return pin levels
   output var  logic [7:0] rdata_ff,        // read data, cycle after rd
   input  wire logic [7:0] p0_in,           // port 0 pin levels
   output var  logic [7:0] p0_out_ff,       // port 0 drive value
   output var  logic [7:0] p0_oe_n_ff,      // port 0 drive enable, low drives
   output var  logic [7:0] p0_pullup_en_ff, // port 0 weak pull-up on
   input  wire logic [7:0] p1_in,           // port 1 pin levels
   output var  logic [7:0] p1_out_ff,       // port 1 drive value
   output var  logic [7:0] p1_oe_n_ff,      // port 1 drive enable, low drives
   output var  logic [7:0] p1_pullup_en_ff, // port 1 weak pull-up on
   input  wire logic [2:0] p2_in,           // port 2 pin levels
   output var  logic [2:0] p2_out_ff,       // port 2 drive value
   output var  logic [2:0] p2_oe_n_ff,      // port 2 drive enable, low drives
   output var  logic [2:0] p2_pullup_en_ff, // port 2 weak pull-up on
   output var  logic       p2_3_out_ff,     // write-only port 2 bit 3 pin
   output var  logic       rst_pullup_en_ff // reset pin weak pull-up on
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] port0_latch_ff;
   logic [7:0] port1_latch_ff;
   logic [3:0] port2_latch_ff;
   logic [7:0] modulation_pin_select_ff;
   logic       carrier_global_enable_ff;
   logic [7:0] port0_pullup_disable_ff;
   logic [7:0] port1_pullup_disable_ff;
   logic [7:0] port2_pullup_disable_ff;
   logic       wave;
   logic [7:0] mod0;
   logic [7:0] mod1;
   logic [7:0] lvl0;
   logic [7:0] lvl1;
   logic [7:0] nxt_rdata;

   wire wr_p0  = wr && addr == ADDR_PORT0;
   wire wr_p1  = wr && addr == ADDR_PORT1;
   wire wr_p2  = wr && addr == ADDR_PORT2;
   wire wr_sel = wr && addr == ADDR_MOD_SEL;
   wire wr_cfg = wr && addr == ADDR_CFG;
   wire wr_pu0 = wr && addr == ADDR_PU0;
   wire wr_pu1 = wr && addr == ADDR_PU1;
   wire wr_pu2 = wr && addr == ADDR_PU2;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         port0_latch_ff <= PORT_LATCH_RST;
      end else if (wr_p0) begin
         port0_latch_ff <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         port1_latch_ff <= PORT_LATCH_RST;
      end else if (wr_p1) begin
         port1_latch_ff <= wdata;
      end
   end

   // upper four bits unused, they read back as ones
   always_ff @(posedge clk) begin
      if (!resetn) begin
         port2_latch_ff <= P2_LATCH_RST;
      end else if (wr_p2) begin
         port2_latch_ff <= wdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         modulation_pin_select_ff <= MOD_SEL_RST;
      end else if (wr_sel) begin
         modulation_pin_select_ff <= wdata;
      end
   end

   // only the carrier enable lives here; other bits belong elsewhere
   always_ff @(posedge clk) begin
      if (!resetn) begin
         carrier_global_enable_ff <= 1'b0;
      end else if (wr_cfg) begin
         carrier_global_enable_ff <= wdata[CFG_CARRIER_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         port0_pullup_disable_ff <= PU_RST;
         port1_pullup_disable_ff <= PU_RST;
         port2_pullup_disable_ff <= PU_RST;
      end else begin
         if (wr_pu0) begin
            port0_pullup_disable_ff <= wdata;
         end
         if (wr_pu1) begin
            port1_pullup_disable_ff <= wdata;
         end
         if (wr_pu2) begin
            port2_pullup_disable_ff <= wdata & PU2_RD_MASK;
         end
      end
   end

   // ------------------------------------------------------------
   // carrier and pin drive
   // ------------------------------------------------------------
   carrier_gen #(
      .HALF_CYC (CARRIER_HALF_CYC)
   ) u_carrier (
      .clk     (clk),
      .resetn  (resetn),
      .wave_ff (wave)
   );

   always_comb begin
      mod0          = 8'h00;
      mod1          = 8'h00;
      mod0[7]       = modulation_pin_select_ff[SEL_P07];
      mod0[5]       = modulation_pin_select_ff[SEL_P05];
      mod0[3]       = modulation_pin_select_ff[SEL_P03];
      mod0[2]       = modulation_pin_select_ff[SEL_P02];
      mod1[6]       = modulation_pin_select_ff[SEL_P16];
      mod1[5]       = modulation_pin_select_ff[SEL_P15];
      mod1[4]       = modulation_pin_select_ff[SEL_P14];
      mod1[1]       = modulation_pin_select_ff[SEL_P11];
   end

   assign lvl0 = port0_latch_ff ^ (mod0 & {8{carrier_global_enable_ff & wave}});
   assign lvl1 = port1_latch_ff ^ (mod1 & {8{carrier_global_enable_ff & wave}});

   // a high level is never driven: released to pull-up or to float
   always_ff @(posedge clk) begin
      if (!resetn) begin
         p0_out_ff  <= 8'hff;
         p0_oe_n_ff <= 8'hff;
         p1_out_ff  <= 8'hff;
         p1_oe_n_ff <= 8'hff;
         p2_out_ff  <= 3'h7;
         p2_oe_n_ff <= 3'h7;
      end else begin
         p0_out_ff  <= lvl0;
         p0_oe_n_ff <= lvl0;
         p1_out_ff  <= lvl1;
         p1_oe_n_ff <= lvl1;
         p2_out_ff  <= port2_latch_ff[P2_PINS-1:0];
         p2_oe_n_ff <= port2_latch_ff[P2_PINS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         p0_pullup_en_ff  <= 8'hff;
         p1_pullup_en_ff  <= 8'hff;
         p2_pullup_en_ff  <= 3'h7;
         rst_pullup_en_ff <= 1'b1;
         p2_3_out_ff      <= 1'b1;
      end else begin
         p0_pullup_en_ff  <= ~port0_pullup_disable_ff;
         p1_pullup_en_ff  <= ~port1_pullup_disable_ff;
         p2_pullup_en_ff  <= ~port2_pullup_disable_ff[P2_PINS-1:0];
         rst_pullup_en_ff <= ~port2_pullup_disable_ff[PU2_RST_PIN_BIT];
         p2_3_out_ff      <= port2_latch_ff[P2_WO_BIT];
      end
   end

   // ------------------------------------------------------------
   // read side
   // ------------------------------------------------------------
   always_comb begin
      nxt_rdata = 8'h00;
      case (addr)
         ADDR_PORT0:   nxt_rdata = pin_read ? p0_in : port0_latch_ff;
         ADDR_PORT1:   nxt_rdata = pin_read ? p1_in : port1_latch_ff;
         ADDR_PORT2: begin
            nxt_rdata = {P2_UNUSED_RD, port2_latch_ff};
            if (pin_read) begin
               nxt_rdata[P2_PINS-1:0] = p2_in;
            end
         end
         ADDR_MOD_SEL: nxt_rdata = modulation_pin_select_ff;
         ADDR_CFG:     nxt_rdata[CFG_CARRIER_EN_BIT] = carrier_global_enable_ff;
         ADDR_PU0:     nxt_rdata = port0_pullup_disable_ff;
         ADDR_PU1:     nxt_rdata = port1_pullup_disable_ff;
         ADDR_PU2:     nxt_rdata = port2_pullup_disable_ff;
         default:      nxt_rdata = 8'h00;
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence seq_p0_write;
      wr && addr == ADDR_PORT0;
   endsequence

   sequence seq_p0_latch_read;
      rd && !pin_read && addr == ADDR_PORT0;
   endsequence

   sequence seq_p1_pin_read;
      rd && pin_read && addr == ADDR_PORT1;
   endsequence

   sequence seq_p16_modulated;
      carrier_global_enable_ff && modulation_pin_select_ff[SEL_P16];
   endsequence

   AST_LOW_DRIVE: assert property (!port0_latch_ff[0] |=> !p0_oe_n_ff[0] && !p0_out_ff[0])
      else $error("latched zero not driven low");
   AST_ONE_RELEASED: assert property (port0_latch_ff[1] |=> p0_oe_n_ff[1])
      else $error("latched one not released");
   AST_NO_HIGH_DRIVE: assert property ((~p1_oe_n_ff & p1_out_ff) == 8'h00)
      else $error("pin actively driven high");
   AST_OD_INPUT: assert property (port1_pullup_disable_ff[2] && port1_latch_ff[2]
      |=> p1_oe_n_ff[2] && !p1_pullup_en_ff[2])
      else $error("open-drain input not floating");
   AST_MOD_P03: assert property (carrier_global_enable_ff && modulation_pin_select_ff[SEL_P03]
      && !port0_latch_ff[3] |=> p0_oe_n_ff[3] == $past(wave))
      else $error("modulated pin does not follow carrier");
   AST_MOD_OFF: assert property (!carrier_global_enable_ff |=> p1_oe_n_ff == $past(port1_latch_ff))
      else $error("modulation active while globally off");
   AST_MOD_P11: assert property (carrier_global_enable_ff && modulation_pin_select_ff[SEL_P11]
      |=> p1_out_ff[1] == ($past(port1_latch_ff[1]) ^ $past(wave)))
      else $error("select bit 4 does not modulate pin 1.1");
   AST_PU0_WRITE: assert property (wr_pu0 ##1 !wr_pu0 |=> p0_pullup_en_ff == ~$past(wdata, 2))
      else $error("port 0 pull-up not per written bits");
   AST_PU1_RESET: assert property ($past(!resetn) |-> port1_pullup_disable_ff == PU_RST)
      else $error("port 1 pull-ups not enabled after reset");
   AST_RST_PULLUP: assert property (wr_pu2 ##1 !wr_pu2
      |=> rst_pullup_en_ff == !$past(wdata[PU2_RST_PIN_BIT], 2))
      else $error("reset pin pull-up not per bit 5");
   AST_P0_ROUNDTRIP: assert property (seq_p0_write ##1 seq_p0_latch_read |=> rdata_ff == $past(wdata, 2))
      else $error("port 0 latch read-back wrong");
   AST_P1_RESET: assert property ($past(!resetn) |-> port1_latch_ff == PORT_LATCH_RST)
      else $error("port 1 latch not ones after reset");
   AST_PIN_READ: assert property (rd && pin_read && addr == ADDR_PORT0 |=> rdata_ff == $past(p0_in))
      else $error("pin read returned wrong level");
   AST_P1_PIN_READ: assert property (seq_p1_pin_read |=> rdata_ff == $past(p1_in))
      else $error("port 1 pin read returned wrong level");
   AST_P1_LATCH_READ: assert property (rd && !pin_read && addr == ADDR_PORT1
      |=> rdata_ff == $past(port1_latch_ff))
      else $error("port 1 latch read returned wrong value");
   AST_RDATA_IDLE: assert property (!rd |=> rdata_ff == 8'h00)
      else $error("read data present without a read strobe");
   AST_CFG_READ: assert property (rd && addr == ADDR_CFG
      |=> rdata_ff[CFG_CARRIER_EN_BIT] == $past(carrier_global_enable_ff))
      else $error("carrier enable read back wrong");
   AST_MOD_P16: assert property (seq_p16_modulated
      |=> p1_oe_n_ff[6] == ($past(port1_latch_ff[6]) ^ $past(wave)))
      else $error("select bit 7 does not modulate pin 1.6");
   AST_UNSELECTED: assert property (1'b1
      |=> (p0_oe_n_ff & ~$past(mod0)) == ($past(port0_latch_ff) & ~$past(mod0)))
      else $error("unselected port 0 pin follows the carrier");
   AST_PU1_FOLLOW: assert property (1'b1 |=> p1_pullup_en_ff == ~$past(port1_pullup_disable_ff))
      else $error("port 1 pull-up enable does not follow its register");
   AST_PU2_RESERVED: assert property ((port2_pullup_disable_ff & ~PU2_RD_MASK) == 8'h00)
      else $error("reserved port 2 pull-up bit stored");
   AST_SEL_RESET: assert property ($past(!resetn) |-> modulation_pin_select_ff == MOD_SEL_RST)
      else $error("select bits not clear after reset");
   AST_P0_RESET: assert property ($past(!resetn) |-> port0_latch_ff == PORT_LATCH_RST)
      else $error("port 0 latch not ones after reset");
   AST_PU0_RESET: assert property ($past(!resetn) |-> port0_pullup_disable_ff == PU_RST)
      else $error("port 0 pull-ups not enabled after reset");
   AST_P2_DRIVE: assert property (1'b1 |=> p2_oe_n_ff == $past(port2_latch_ff[P2_PINS-1:0]))
      else $error("port 2 pins do not follow their latch");
endmodule
`default_nettype wire

// file: verification/pin_world.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// wires and external parts hanging on one port
// ------------------------------------------------------------
module pin_world #(
   parameter int W = 8
) (
   input  wire logic         clk,       // core clock
   input  wire logic [W-1:0] oe_n,      // device drive enable, low drives low
   input  wire logic [W-1:0] pullup_en, // device weak pull-up on
   input  wire logic [W-1:0] ext_en,    // external part drives the wire
   input  wire logic [W-1:0] ext_val,   // level the external part drives
   output var  logic [W-1:0] level      // resolved wire level
);
   logic [W-1:0] last_ff;

   // only a held wire updates the memory, so a floating one stays put
   always_ff @(posedge clk) begin
      for (int i = 0; i < W; i++) begin
         if (!oe_n[i] || ext_en[i] || pullup_en[i]) begin
            last_ff[i] <= level[i];
         end
      end
   end

   // floating wire shows the inverse of its last held level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!oe_n[i]) begin
            level[i] = 1'b0;
         end else if (ext_en[i]) begin
            level[i] = ext_val[i];
         end else if (pullup_en[i]) begin
            level[i] = 1'b1;
         end else begin
            level[i] = ~last_ff[i];
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check(g, e)
module tb_top;
   import gpio_pkg::*;
   logic       clk, resetn, wr, rd, pin_read;
   logic [7:0] addr, wdata, rdata_ff, p0_in, p0_out_ff, p0_oe_n_ff, p0_pullup_en_ff;
   logic [7:0] p1_in, p1_out_ff, p1_oe_n_ff, p1_pullup_en_ff, ext0_en, ext0_val, rv, c0, c1, ext1_en, ext1_val;
   logic [2:0] p2_in, p2_out_ff, p2_oe_n_ff, p2_pullup_en_ff;
   logic       p2_3_out_ff, rst_pullup_en_ff;
   int         fail_count, checked;
   logic [7:0] ra [7] = '{8'h80, 8'h90, 8'h9f, 8'hb2, 8'hb3, 8'hb4, 8'h55};
   logic [7:0] re [7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   gpio_port dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .pin_read(pin_read), .rdata_ff(rdata_ff), .p0_in(p0_in), .p0_out_ff(p0_out_ff),
      .p0_oe_n_ff(p0_oe_n_ff), .p0_pullup_en_ff(p0_pullup_en_ff), .p1_in(p1_in),
      .p1_out_ff(p1_out_ff), .p1_oe_n_ff(p1_oe_n_ff), .p1_pullup_en_ff(p1_pullup_en_ff),
      .p2_in(p2_in), .p2_out_ff(p2_out_ff), .p2_oe_n_ff(p2_oe_n_ff),
      .p2_pullup_en_ff(p2_pullup_en_ff), .p2_3_out_ff(p2_3_out_ff),
      .rst_pullup_en_ff(rst_pullup_en_ff));
   pin_world #(.W(8)) w0 (.clk(clk), .oe_n(p0_oe_n_ff), .pullup_en(p0_pullup_en_ff),
      .ext_en(ext0_en), .ext_val(ext0_val), .level(p0_in));
   pin_world #(.W(8)) w1 (.clk(clk), .oe_n(p1_oe_n_ff), .pullup_en(p1_pullup_en_ff),
      .ext_en(ext1_en), .ext_val(ext1_val), .level(p1_in));
   pin_world #(.W(3)) w2 (.clk(clk), .oe_n(p2_oe_n_ff), .pullup_en(p2_pullup_en_ff),
      .ext_en(3'h0), .ext_val(3'h0), .level(p2_in));

   // ------------------------------------------------------------
   // clock and bus tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic pr, output logic [7:0] d);
      @(posedge clk);
      addr     <= a;
      pin_read <= pr;
      rd       <= 1'b1;
      @(posedge clk);
      rd       <= 1'b0;
      #1;
      d = rdata_ff;
   endtask

   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // a carrier edge is bound to come within one half period of 3289 clocks
   task automatic watch(output logic [7:0] ch0, output logic [7:0] ch1);
      logic [7:0] s0, s1;
      s0  = p0_oe_n_ff;
      s1  = p1_oe_n_ff;
      ch0 = 8'h00;
      ch1 = 8'h00;
      repeat (3400) begin
         @(posedge clk);
         #1;
         ch0 |= p0_oe_n_ff ^ s0;
         ch1 |= p1_oe_n_ff ^ s1;
         `CHK(~p0_oe_n_ff & p0_out_ff, 8'h00);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      {resetn, wr, rd, pin_read, addr, wdata, ext0_en, ext0_val, ext1_en, ext1_val} = '0;
      fail_count = 0;
      checked    = 0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      #1;
      `CHK(p0_oe_n_ff & p1_oe_n_ff, 8'hff);
      `CHK(p0_pullup_en_ff & p1_pullup_en_ff, 8'hff);
      `CHK({4'h0, p2_pullup_en_ff, rst_pullup_en_ff}, 8'h0f);
      for (int i = 0; i < 7; i++) begin
         rd_reg(ra[i], 1'b0, rv);
         `CHK(rv, re[i]);
      end
      wr_reg(8'h80, 8'h5a);
      wr_reg(8'h90, 8'ha5);
      wr_reg(8'h55, 8'hff);
      rd_reg(8'h80, 1'b0, rv);
      `CHK(rv, 8'h5a);
      rd_reg(8'h90, 1'b0, rv);
      `CHK(rv, 8'ha5);
      rd_reg(8'h55, 1'b0, rv);
      `CHK(rv, 8'h00);
      `CHK(p0_oe_n_ff, 8'h5a);
      `CHK(p1_oe_n_ff, 8'ha5);
      wr_reg(8'ha0, 8'h05);
      settle();
      `CHK({1'b0, p2_3_out_ff, p2_oe_n_ff, p2_out_ff}, 8'h2d);
      rd_reg(8'ha0, 1'b1, rv);
      `CHK(rv, 8'hf5);
      wr_reg(8'hb2, 8'h0f);
      wr_reg(8'hb3, 8'hf4);
      wr_reg(8'hb4, 8'h27);
      // released port 1 pins without pull-up are set from outside
      ext1_en  <= 8'ha4;
      ext1_val <= 8'h84;
      settle();
      `CHK(p0_pullup_en_ff, 8'hf0);
      `CHK(p1_pullup_en_ff, 8'h0b);
      `CHK({4'h0, p2_pullup_en_ff, rst_pullup_en_ff}, 8'h00);
      rd_reg(8'hb4, 1'b0, rv);
      `CHK(rv, 8'h27);
      rd_reg(8'h90, 1'b1, rv);
      `CHK(rv, 8'h85);
      // latch ones act as inputs: pulled-up nibble and two open-drain pins
      wr_reg(8'h80, 8'hf3);
      ext0_en  <= 8'hc3;
      ext0_val <= 8'h41;
      settle();
      `CHK(p0_oe_n_ff, 8'hf3);
      rd_reg(8'h80, 1'b1, rv);
      `CHK(rv, 8'h71);
      rd_reg(8'h80, 1'b0, rv);
      `CHK(rv, 8'hf3);
      ext0_en <= 8'h00;
      ext1_en <= 8'h00;
      wr_reg(8'h80, 8'h00);
      wr_reg(8'h90, 8'h00);
      wr_reg(8'h9f, 8'hff);
      wr_reg(8'haf, 8'h10);
      settle();
      watch(c0, c1);
      `CHK(c0, 8'hac);
      `CHK(c1, 8'h72);
      wr_reg(8'haf, 8'h00);
      settle();
      watch(c0, c1);
      `CHK(c0 | c1, 8'h00);
      // reset in mid-run: everything written so far falls back
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      `CHK(p0_oe_n_ff & p1_oe_n_ff, 8'hff);
      `CHK(p0_pullup_en_ff & p1_pullup_en_ff, 8'hff);
      `CHK({4'h0, p2_pullup_en_ff, rst_pullup_en_ff}, 8'h0f);
      rd_reg(8'h9f, 1'b0, rv);
      `CHK(rv, 8'h00);
      rd_reg(8'haf, 1'b0, rv);
      `CHK(rv, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
